// [rtl/tesc_timer.sv]
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module tesc_timer (
   // Clock and reset
   input  wire logic                        i_clk_sys,
   input  wire logic                        i_sys_rst,
   // Register port
   input  wire logic [tesc_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [31:0]                 i_wdata,
   input  wire logic                        i_wr_en,
   input  wire logic                        i_rd_en,
   output      logic [31:0]                 o_rdata,
   // Timer events
   input  wire logic [tesc_pkg::NUM_CH-1:0] i_capture,
   input  wire logic                        i_restart_trig,
   input  wire logic                        i_trigger_in,
   output      logic                        o_update_event,
   output      logic                        o_trigger_event,
   output      logic [15:0]                 o_count,
   // Interrupt
   output      logic                        o_irq
);
   import tesc_pkg::*;

   typedef struct packed {
      logic [15:0]       cnt;
      logic [15:0]       psc;
      logic [15:0]       psc_act;
      logic [15:0]       psc_cnt;
      logic [15:0]       reload;
      logic [3:0][15:0]  ccr;
      logic [3:0][15:0]  ccr_act;
      logic [3:0]        ccif;
      logic [3:0]        ocf;
      logic              update_flag;
      logic              trigger_flag;
      logic [10:0]       ien;
      logic [10:0]       gen;
      logic [10:0]       cfg;
      tesc_dir_e         dir;
      logic              update_event;
      logic              trigger_event;
      logic [31:0]       rdata;
   } tesc_state_s;

   tesc_state_s s_q;
   tesc_state_s s_d;

   function automatic logic [31:0] tesc_status(input tesc_state_s s);
      tesc_status = {21'h000000, s.trigger_flag, 1'b0, s.update_flag, s.ocf, s.ccif};
   endfunction : tesc_status

   function automatic logic [31:0] tesc_read(input tesc_state_s s, input logic [11:0] a);
      logic [31:0] r;
      r = 32'h00000000;
      if (a == OFF_IEN) begin
         r = {21'h000000, s.ien};
      end else if (a == OFF_STATUS) begin
         r = tesc_status(s);
      end else if (a == OFF_COUNT) begin
         r = {16'h0000, s.cnt};
      end else if (a == OFF_PRESCALE) begin
         r = {16'h0000, s.psc};
      end else if (a == OFF_RELOAD) begin
         r = {16'h0000, s.reload};
      end else if (a >= OFF_CCR0 && a <= OFF_CCR3 && a[1:0] == 2'b00) begin
         r = {16'h0000, s.ccr[a[3:2]]};
      end else if (a == OFF_CONFIG) begin
         r = {21'h000000, s.cfg};
      end
      tesc_read = r;   // Generate register and unmapped space read zero
   endfunction : tesc_read

   logic       tick;
   logic       uev_hw;
   logic       update_event;
   logic       trigger_event;
   logic       center;
   logic [1:0] mode;
   logic [3:0] is_input;
   logic [3:0] cap;
   logic       ccr_hit;

   always_comb begin
      s_d      = s_q;
      s_d.gen  = 11'h000;
      s_d.update_event  = 1'b0;
      s_d.trigger_event  = 1'b0;
      uev_hw   = 1'b0;
      mode     = s_q.cfg[CFG_MODE_LO +: 2];
      center   = (mode == TESC_MODE_CENTER);
      is_input = s_q.cfg[CFG_INPUT_LO +: 4];
      tick     = s_q.cfg[CFG_ENABLE] && (s_q.psc_cnt == s_q.psc_act);
      ccr_hit  = (i_addr >= OFF_CCR0) && (i_addr <= OFF_CCR3) && (i_addr[1:0] == 2'b00);

      // Register reads
      if (i_rd_en) begin
         s_d.rdata = tesc_read(s_q, i_addr);
         if (ccr_hit && is_input[i_addr[3:2]]) begin
            s_d.ccif[i_addr[3:2]] = 1'b0;
         end
      end

      // Register writes; reserved bits dropped
      if (i_wr_en) begin
         if (i_addr == OFF_IEN) begin
            s_d.ien = i_wdata[10:0] & IEN_MASK;
         end else if (i_addr == OFF_GEN) begin
            s_d.gen = i_wdata[10:0] & GEN_MASK;
         end else if (i_addr == OFF_STATUS) begin
            s_d.ccif  = s_d.ccif & i_wdata[3:0];
            s_d.ocf   = s_q.ocf & i_wdata[7:4];
            s_d.update_flag = s_q.update_flag & i_wdata[BIT_UPDATE];
            s_d.trigger_flag = s_q.trigger_flag & i_wdata[BIT_TRIGGER];
         end else if (i_addr == OFF_COUNT) begin
            s_d.cnt = i_wdata[15:0];
         end else if (i_addr == OFF_PRESCALE) begin
            s_d.psc = i_wdata[15:0];
         end else if (i_addr == OFF_RELOAD) begin
            s_d.reload = i_wdata[15:0];
         end else if (ccr_hit) begin
            s_d.ccr[i_addr[3:2]] = i_wdata[15:0];
            if (!s_q.cfg[CFG_PRE_LO + i_addr[3:2]]) begin
               s_d.ccr_act[i_addr[3:2]] = i_wdata[15:0];
            end
         end else if (i_addr == OFF_CONFIG) begin
            s_d.cfg = i_wdata[10:0] & CFG_MASK;
         end
      end

      // Prescaler and counter
      if (tick) begin
         s_d.psc_cnt = 16'h0000;
         if (center) begin
            if (s_q.dir == TESC_DIR_UP) begin
               if (s_q.cnt >= s_q.reload) begin
                  s_d.dir = TESC_DIR_DOWN;
                  s_d.cnt = s_q.cnt - 16'h0001;
                  uev_hw  = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt + 16'h0001;
               end
            end else begin
               if (s_q.cnt == 16'h0000) begin
                  s_d.dir = TESC_DIR_UP;
                  s_d.cnt = 16'h0001;
                  uev_hw  = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt - 16'h0001;
               end
            end
         end else if (mode == TESC_MODE_DOWN) begin
            if (s_q.cnt == 16'h0000) begin
               s_d.cnt = s_q.reload;
               uev_hw  = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt - 16'h0001;
            end
         end else begin
            if (s_q.cnt >= s_q.reload) begin
               s_d.cnt = 16'h0000;
               uev_hw  = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt + 16'h0001;
            end
         end
      end else if (s_q.cfg[CFG_ENABLE]) begin
         s_d.psc_cnt = s_q.psc_cnt + 16'h0001;
      end

      // Output compare match, suppressed in center mode
      for (int i = 0; i < NUM_CH; i++) begin
         if (tick && !center && !is_input[i] && s_q.cnt == s_q.ccr_act[i]) begin
            s_d.ccif[i] = 1'b1;
         end
      end

      // Update event
      update_event = uev_hw || s_q.gen[BIT_UPDATE] || i_restart_trig;
      if (s_q.gen[BIT_UPDATE] || i_restart_trig) begin
         s_d.cnt     = (mode == TESC_MODE_DOWN) ? s_q.reload : 16'h0000;
         s_d.psc_cnt = 16'h0000;
         s_d.dir     = TESC_DIR_UP;
      end
      if (update_event) begin
         s_d.psc_act = s_d.psc;
         for (int i = 0; i < NUM_CH; i++) begin
            if (s_q.cfg[CFG_PRE_LO + i] && !is_input[i]) begin
               s_d.ccr_act[i] = s_d.ccr[i];
            end
         end
         s_d.update_flag = 1'b1;
         s_d.update_event   = 1'b1;
      end

      // Trigger event
      trigger_event = s_q.gen[BIT_TRIGGER] || i_trigger_in;
      if (trigger_event) begin
         s_d.trigger_flag = 1'b1;
         s_d.trigger_event   = 1'b1;
      end

      // Captures and software channel events
      for (int i = 0; i < NUM_CH; i++) begin
         cap[i] = is_input[i] && (i_capture[i] || s_q.gen[i]);
         if (cap[i]) begin
            s_d.ccr[i]     = s_q.cnt;
            s_d.ccr_act[i] = s_q.cnt;
            if (s_q.ccif[i]) begin
               s_d.ocf[i] = 1'b1;
            end
            s_d.ccif[i] = 1'b1;
         end else if (!is_input[i] && s_q.gen[i]) begin
            s_d.ccif[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         s_q         <= '0;
         s_q.cnt     <= RST_COUNT;
         s_q.psc     <= RST_PRESCALE;
         s_q.psc_act <= RST_PRESCALE;
         s_q.reload  <= RST_RELOAD;
         s_q.ccr     <= {NUM_CH{RST_CCR}};
         s_q.ccr_act <= {NUM_CH{RST_CCR}};
         s_q.dir     <= TESC_DIR_UP;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata         = s_q.rdata;
   assign o_update_event  = s_q.update_event;
   assign o_trigger_event = s_q.trigger_event;
   assign o_count         = s_q.cnt;
   assign o_irq           = |({s_q.trigger_flag, 1'b0, s_q.update_flag, 4'h0, s_q.ccif} & s_q.ien);

   a_trig_gen_flag: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_wr_en && i_addr == OFF_GEN && i_wdata[BIT_TRIGGER] |-> ##2 (o_trigger_event && s_q.trigger_flag))
      else $error("trigger generate did not raise trigger event");

   a_gen_self_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_wr_en && i_addr == OFF_GEN ##1 !(i_wr_en && i_addr == OFF_GEN) |=> s_q.gen == 11'h000)
      else $error("generate bits did not self clear");

   a_upd_reinit: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_wr_en && i_addr == OFF_GEN && i_wdata[BIT_UPDATE] && s_q.cfg[CFG_MODE_LO +: 2] == TESC_MODE_UP)
      ##1 !i_wr_en |=> (o_count == 16'h0000 && o_update_event && s_q.update_flag))
      else $error("update generate did not reinitialise counter");

   a_capture_copy: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.cfg[CFG_INPUT_LO] && i_capture[0] && !i_wr_en |=> (s_q.ccr[0] == $past(s_q.cnt) && s_q.ccif[0]))
      else $error("capture did not copy counter");

   a_overrun_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.cfg[CFG_INPUT_LO] && i_capture[0] && s_q.ccif[0] |=> s_q.ocf[0])
      else $error("overrun flag missed");

   a_update_sticky: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.update_flag && !(i_wr_en && i_addr == OFF_STATUS && !i_wdata[BIT_UPDATE]) |=> s_q.update_flag)
      else $error("update flag lost without clear");

   a_set_wins: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_restart_trig && i_wr_en && i_addr == OFF_STATUS |=> s_q.update_flag)
      else $error("flag clear beat hardware set");

   a_gen_reads_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_rd_en && i_addr == OFF_GEN |=> o_rdata == 32'h00000000)
      else $error("generate register read non zero");

   a_irq_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $rose(s_q.update_flag) && s_q.ien[BIT_UPDATE] |-> o_irq ##0 (s_q.ien != 11'h000))
      else $error("enabled flag gave no interrupt");

   a_reset_vals: assert property (@(posedge i_clk_sys)
      i_sys_rst |=> (s_q.reload == RST_RELOAD && s_q.psc == RST_PRESCALE && o_count == RST_COUNT))
      else $error("wrong values after reset");

   a_trig_ext_flag: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_trigger_in |=> (o_trigger_event && s_q.trigger_flag))
      else $error("external trigger did not set trigger flag");

   a_trig_sticky: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.trigger_flag && !(i_wr_en && i_addr == OFF_STATUS && !i_wdata[BIT_TRIGGER]) |=> s_q.trigger_flag)
      else $error("trigger flag lost without clear");

   a_restart_update: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_restart_trig |=> (o_update_event && s_q.update_flag))
      else $error("restart trigger gave no update event");

   a_restart_reinit: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_restart_trig && s_q.cfg[CFG_MODE_LO +: 2] == TESC_MODE_UP |=> o_count == 16'h0000)
      else $error("restart did not reinitialise counter");

   a_out_gen_flag: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_wr_en && i_addr == OFF_GEN && i_wdata[3] && !is_input[3] ##1 !i_wr_en
      |=> (s_q.ccif[3] && $stable(s_q.ccr[3])))
      else $error("output channel generate misbehaved");

   a_capture_copy1: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.cfg[CFG_INPUT_LO + 1] && i_capture[1] |=> (s_q.ccr[1] == $past(s_q.cnt) && s_q.ccif[1]))
      else $error("capture on channel one did not copy counter");

   a_overrun_set1: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.cfg[CFG_INPUT_LO + 1] && i_capture[1] && s_q.ccif[1] |=> s_q.ocf[1])
      else $error("overrun flag missed on channel one");

   a_overrun_sticky: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.ocf[1] && !(i_wr_en && i_addr == OFF_STATUS && !i_wdata[BIT_OVR_LO + 1]) |=> s_q.ocf[1])
      else $error("overrun flag lost without clear");

   a_center_no_match: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.cfg[CFG_MODE_LO +: 2] == TESC_MODE_CENTER && !is_input[0] && !s_q.ccif[0] && !i_wr_en
      && !s_q.gen[0] |=> !s_q.ccif[0])
      else $error("match flag set in center mode");

   a_match_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      tick && !center && !is_input[0] && s_q.cnt == s_q.ccr_act[0] |=> s_q.ccif[0])
      else $error("compare match did not set flag");

   a_read_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_rd_en && i_addr == OFF_CCR0 + 12'h004 && s_q.cfg[CFG_INPUT_LO + 1] && !i_capture[1]
      && !s_q.gen[1] |=> !s_q.ccif[1])
      else $error("compare read did not clear input flag");

   a_count_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.cfg[CFG_ENABLE] && !tick && !i_wr_en && s_q.gen == 11'h000 && !i_restart_trig
      |=> $stable(o_count))
      else $error("counter moved between prescaler ticks");

   a_reload_down: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      tick && mode == TESC_MODE_DOWN && s_q.cnt == 16'h0000 && !s_q.gen[BIT_UPDATE] && !i_restart_trig
      |=> o_count == $past(s_q.reload))
      else $error("down counter did not reload");

   a_irq_quiet: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.ien == 11'h000 |-> !o_irq)
      else $error("interrupt raised with all enables off");

   a_preload_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_q.cfg[CFG_PRE_LO] && !is_input[0] && i_wr_en && i_addr == OFF_CCR0 && !update_event
      |=> s_q.ccr_act[0] == $past(s_q.ccr_act[0]))
      else $error("preloaded compare took effect early");

   a_preload_move: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      update_event && s_q.cfg[CFG_PRE_LO] && !is_input[0] && !(i_wr_en && i_addr == OFF_CCR0)
      |=> s_q.ccr_act[0] == s_q.ccr[0])
      else $error("preloaded compare not moved on update");

   a_status_layout: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_rd_en && i_addr == OFF_STATUS |=> o_rdata[7:0] == {$past(s_q.ocf), $past(s_q.ccif)})
      else $error("status flags read in wrong positions");

   a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_rd_en |=> o_rdata[31:16] == 16'h0000)
      else $error("reserved read bits not zero");

   a_trig_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_wr_en && i_addr == OFF_STATUS && !i_wdata[BIT_TRIGGER] && !trigger_event |=> !s_q.trigger_flag)
      else $error("written zero did not clear trigger flag");
endmodule : tesc_timer

// [rtl/tesc_pkg.sv]
package tesc_pkg;
   localparam int          ADDR_W       = 12;
   localparam int          NUM_CH       = 4;
   // Register byte offsets
   localparam logic [11:0] OFF_IEN      = 12'h074;
   localparam logic [11:0] OFF_GEN      = 12'h078;
   localparam logic [11:0] OFF_STATUS   = 12'h07C;
   localparam logic [11:0] OFF_COUNT    = 12'h080;
   localparam logic [11:0] OFF_PRESCALE = 12'h084;
   localparam logic [11:0] OFF_RELOAD   = 12'h088;
   localparam logic [11:0] OFF_CCR0     = 12'h090;
   localparam logic [11:0] OFF_CCR3     = 12'h09C;
   localparam logic [11:0] OFF_CONFIG   = 12'h0C0;
   // Field positions
   localparam int          BIT_UPDATE   = 8;
   localparam int          BIT_TRIGGER  = 10;
   localparam int          BIT_OVR_LO   = 4;
   localparam int          CFG_INPUT_LO = 0;
   localparam int          CFG_PRE_LO   = 4;
   localparam int          CFG_ENABLE   = 8;
   localparam int          CFG_MODE_LO  = 9;
   // Writable bit masks
   localparam logic [10:0] IEN_MASK     = 11'h50F;
   localparam logic [10:0] GEN_MASK     = 11'h50F;
   localparam logic [10:0] CFG_MASK     = 11'h7FF;
   // Values after reset
   localparam logic [15:0] RST_COUNT    = 16'h0000;
   localparam logic [15:0] RST_PRESCALE = 16'h0000;
   localparam logic [15:0] RST_RELOAD   = 16'hFFFF;
   localparam logic [15:0] RST_CCR      = 16'h0000;

   typedef enum logic [1:0] {
      TESC_MODE_UP     = 2'b00,
      TESC_MODE_DOWN   = 2'b01,
      TESC_MODE_CENTER = 2'b11
   } tesc_mode_e;

   typedef enum logic {
      TESC_DIR_UP   = 1'b0,
      TESC_DIR_DOWN = 1'b1
   } tesc_dir_e;
endpackage : tesc_pkg

// [test/tb_tesc_timer.sv]
`timescale 1ns/100ps
module tb_tesc_timer;
   import tesc_pkg::*;
   logic        i_clk_sys      = 1'b0;
   logic        i_sys_rst      = 1'b1;
   logic [11:0] i_addr         = 12'h000;
   logic [31:0] i_wdata        = 32'h0;
   logic        i_wr_en        = 1'b0;
   logic        i_rd_en        = 1'b0;
   logic [3:0]  i_capture      = 4'h0;
   logic        i_restart_trig = 1'b0;
   logic        i_trigger_in   = 1'b0;
   logic [31:0] o_rdata;
   logic        o_update_event;
   logic        o_trigger_event;
   logic [15:0] o_count;
   logic        o_irq;
   int          errors         = 0;
   int          total_checks   = 0;
   int          cycles         = 0;
   int          n;
   int          p;
   logic [15:0] lfsr_q         = 16'h0030;
   logic [31:0] rd_q;
   logic [15:0] div_v;
   logic [15:0] rel_v;
   logic [15:0] cnt_v;
   logic [11:0] addrs [6]      = '{OFF_STATUS, OFF_COUNT, OFF_PRESCALE, OFF_RELOAD, OFF_GEN, 12'h0FC};
   logic [31:0] rst_v [6]      = '{32'h0, 32'h0, 32'h0, 32'h0000FFFF, 32'h0, 32'h0};

   tesc_timer tesc_timer_i (
      .i_clk_sys       (i_clk_sys),
      .i_sys_rst       (i_sys_rst),
      .i_addr          (i_addr),
      .i_wdata         (i_wdata),
      .i_wr_en         (i_wr_en),
      .i_rd_en         (i_rd_en),
      .o_rdata         (o_rdata),
      .i_capture       (i_capture),
      .i_restart_trig  (i_restart_trig),
      .i_trigger_in    (i_trigger_in),
      .o_update_event  (o_update_event),
      .o_trigger_event (o_trigger_event),
      .o_count         (o_count),
      .o_irq           (o_irq)
   );

   always #10 i_clk_sys = ~i_clk_sys;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   task report_and_stop;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   task check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_wr_en <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr_en <= 1'b0;
   endtask : wr

   task rd(input logic [11:0] a);
      @(posedge i_clk_sys);
      i_rd_en <= 1'b1;
      i_addr  <= a;
      @(posedge i_clk_sys);
      i_rd_en <= 1'b0;
      #1 rd_q = o_rdata;
   endtask : rd

   // Bounded wait for one event pulse, then it must drop
   task ev_pulse(input logic trig);
      n = 0;
      #1;
      while ((trig ? o_trigger_event : o_update_event) !== 1'b1 && n < 4) begin
         @(posedge i_clk_sys);
         #1 n++;
      end
      check(32'(n < 4), 32'h1);
      @(posedge i_clk_sys);
      #1 check(32'(trig ? o_trigger_event : o_update_event), 32'h0);
   endtask : ev_pulse

   // Cycles between two update pulses
   task period;
      n = 0;
      while (o_update_event !== 1'b1 && n < 3000) begin
         @(posedge i_clk_sys);
         #1 n++;
      end
      @(posedge i_clk_sys);
      #1 p = 1;
      while (o_update_event !== 1'b1 && p < 3000) begin
         @(posedge i_clk_sys);
         #1 p++;
      end
   endtask : period

   task pulse_in(input int k);
      @(posedge i_clk_sys);
      if (k == 0) i_trigger_in <= 1'b1;
      else if (k == 1) i_restart_trig <= 1'b1;
      else i_capture <= 4'h2;
      @(posedge i_clk_sys);
      i_trigger_in   <= 1'b0;
      i_restart_trig <= 1'b0;
      i_capture      <= 4'h0;
   endtask : pulse_in

   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      repeat (4) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         rd(addrs[k]);
         check(rd_q, rst_v[k]);
      end
      wr(OFF_GEN, 32'h0);
      repeat (3) @(posedge i_clk_sys);
      rd(OFF_STATUS);
      check(rd_q, 32'h0);
      wr(OFF_IEN, 32'h101);
      wr(OFF_CCR0, 32'h1);
      for (int c = 1; c < 4; c++) wr(OFF_CCR0 + 12'(4 * c), 32'hFFFF);
      for (int i = 0; i < 4; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         div_v  = {14'h0, lfsr_q[1:0]};
         rel_v  = 16'h2 + {13'h0, lfsr_q[4:2]};
         wr(OFF_CONFIG, 32'h0);
         wr(OFF_PRESCALE, {lfsr_q, div_v});
         wr(OFF_RELOAD, {~lfsr_q, rel_v});
         rd(OFF_PRESCALE);
         check(rd_q, {16'h0, div_v});
         rd(OFF_RELOAD);
         check(rd_q, {16'h0, rel_v});
         wr(OFF_GEN, 32'h100);
         ev_pulse(1'b0);
         check({16'h0, o_count}, 32'h0);
         wr(OFF_CONFIG, i[0] ? 32'h300 : 32'h100);
         period();
         check(32'(p), 32'((32'(rel_v) + 1) * (32'(div_v) + 1)));
      end
      wr(OFF_STATUS, 32'h0);
      repeat (100) @(posedge i_clk_sys);
      #1 check({31'h0, o_irq}, 32'h1);
      rd(OFF_STATUS);
      check(rd_q, 32'h101);
      wr(OFF_CONFIG, 32'h700);
      wr(OFF_STATUS, 32'h0);
      repeat (100) @(posedge i_clk_sys);
      rd(OFF_STATUS);
      check(rd_q, 32'h100);
      wr(OFF_CONFIG, 32'h4);
      wr(OFF_STATUS, 32'h0);
      #1 check({31'h0, o_irq}, 32'h0);
      lfsr_q = lfsr_next(lfsr_q);
      cnt_v  = lfsr_q;
      wr(OFF_COUNT, {~lfsr_q, cnt_v});
      rd(OFF_COUNT);
      check(rd_q, {16'h0, cnt_v});
      wr(OFF_GEN, 32'h4);
      repeat (3) @(posedge i_clk_sys);
      rd(OFF_STATUS);
      check(rd_q, 32'h4);
      rd(OFF_CCR0 + 12'h8);
      check(rd_q, {16'h0, cnt_v});
      rd(OFF_STATUS);
      check(rd_q, 32'h0);
      rd(OFF_GEN);
      check(rd_q, 32'h0);
      wr(OFF_CONFIG, 32'h2);
      pulse_in(2);
      pulse_in(2);
      repeat (2) @(posedge i_clk_sys);
      rd(OFF_STATUS);
      check(rd_q, 32'h22);
      rd(OFF_CCR0 + 12'h4);
      check(rd_q, {16'h0, cnt_v});
      rd(OFF_STATUS);
      check(rd_q, 32'h20);
      wr(OFF_STATUS, 32'hFFFFFFFF);
      rd(OFF_STATUS);
      check(rd_q, 32'h20);
      wr(OFF_CONFIG, 32'h0);
      wr(OFF_STATUS, 32'h0);
      wr(OFF_GEN, 32'h8);
      repeat (3) @(posedge i_clk_sys);
      rd(OFF_STATUS);
      check(rd_q, 32'h8);
      rd(OFF_CCR3);
      check(rd_q, 32'hFFFF);
      wr(OFF_IEN, 32'h100);
      wr(OFF_STATUS, 32'h0);
      wr(OFF_GEN, 32'h400);
      ev_pulse(1'b1);
      rd(OFF_STATUS);
      check(rd_q, 32'h400);
      check({31'h0, o_irq}, 32'h0);
      pulse_in(0);
      ev_pulse(1'b1);
      pulse_in(1);
      ev_pulse(1'b0);
      rd(OFF_STATUS);
      check(rd_q, 32'h500);
      check({31'h0, o_irq}, 32'h1);
      wr(OFF_STATUS, 32'hFFFFFEFF);
      rd(OFF_STATUS);
      check(rd_q, 32'h400);
      check({31'h0, o_irq}, 32'h0);
      // Preloaded compare on channel 0, moved by a restart
      wr(OFF_CONFIG, 32'h10);
      wr(OFF_CCR0, 32'h3);
      pulse_in(1);
      rd(OFF_CCR0);
      check(rd_q, 32'h3);
      // Restart and status clear in one cycle
      @(posedge i_clk_sys);
      i_restart_trig <= 1'b1;
      i_wr_en        <= 1'b1;
      i_addr         <= OFF_STATUS;
      i_wdata        <= 32'h0;
      @(posedge i_clk_sys);
      i_restart_trig <= 1'b0;
      i_wr_en        <= 1'b0;
      rd(OFF_STATUS);
      check(rd_q, 32'h100);
      report_and_stop();
   end
endmodule : tb_tesc_timer
